// ===== instr_state_switch_exc_link_bench.sv
// self-checking bench for the instruction-state switch and exception link core
`default_nettype none
module instr_state_switch_exc_link_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals and device
    // ------------------------------------------------------------
    logic              ref_clk;
    logic              rstn;
    logic [31:0]       fetch_addr, instr_word, instr_addr, rd_data, pc_wr_target;
    logic              fetch_half, fetch_req, fetch_ack, instr_valid, instr_compact, flush;
    logic [31:0]       fetch_data, wr_data, exc_fault_pc, exc_wide_val, exc_vector;
    logic [3:0]        rd_idx, wr_idx;
    logic              rd_illegal, wr_en, late_arch, op_coproc, op_status_acc, op_undef;
    iss_pkg::iss_wr_t  pc_wr_kind;
    iss_pkg::iss_exc_t exc_kind;
    logic [4:0]        exc_mode;
    logic [31:0]       link_register, current_status_word, saved_status_word;
    int                n_fail;
    int                total_checks;
    int                cycles;

    iss_core u_dut (.ref_clk(ref_clk), .rstn(rstn), .fetch_addr(fetch_addr),
        .fetch_half(fetch_half), .fetch_req(fetch_req), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data), .instr_word(instr_word), .instr_addr(instr_addr),
        .instr_valid(instr_valid), .instr_compact(instr_compact), .flush(flush),
        .rd_idx(rd_idx), .rd_data(rd_data), .rd_illegal(rd_illegal), .wr_en(wr_en),
        .wr_idx(wr_idx), .wr_data(wr_data), .pc_wr_kind(pc_wr_kind),
        .pc_wr_target(pc_wr_target), .late_arch(late_arch), .op_coproc(op_coproc),
        .op_status_acc(op_status_acc), .op_undef(op_undef), .exc_kind(exc_kind),
        .exc_fault_pc(exc_fault_pc), .exc_wide_val(exc_wide_val), .exc_vector(exc_vector),
        .exc_mode(exc_mode), .link_register(link_register),
        .current_status_word(current_status_word), .saved_status_word(saved_status_word));

    // 50 MHz clock; cycle ceiling far above the roughly 90 cycles the tests need
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // pc write, optionally with a fetch answer in the same cycle (which must be refused)
    task automatic do_pcwr(input iss_pkg::iss_wr_t kind, input logic [31:0] tgt, input logic ack);
        @(posedge ref_clk);
        pc_wr_kind   <= kind;
        pc_wr_target <= tgt;
        fetch_ack    <= ack;
        @(posedge ref_clk);
        pc_wr_kind   <= iss_pkg::ISS_WR_NONE;
        pc_wr_target <= ~tgt;
        fetch_ack    <= 1'b0;
        #1;
    endtask

    task automatic do_fetch(input logic [31:0] data);
        @(posedge ref_clk);
        fetch_ack  <= 1'b1;
        fetch_data <= data;
        @(posedge ref_clk);
        fetch_ack  <= 1'b0;
        fetch_data <= ~data;
        #1;
    endtask

    task automatic do_exc(input iss_pkg::iss_exc_t kind, input logic [31:0] fault);
        @(posedge ref_clk);
        exc_kind     <= kind;
        exc_fault_pc <= fault;
        @(posedge ref_clk);
        exc_kind     <= iss_pkg::ISS_EXC_NONE;
        exc_fault_pc <= ~fault;
        #1;
    endtask

    task automatic do_wr(input logic [3:0] idx, input logic [31:0] data);
        @(posedge ref_clk);
        wr_en   <= 1'b1;
        wr_idx  <= idx;
        wr_data <= data;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        wr_data <= ~data;
    endtask

    task automatic do_rd(input logic [3:0] idx);
        @(posedge ref_clk);
        rd_idx <= idx;
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_wide();
        chk(current_status_word, iss_pkg::RESET_STATUS);
        chk(fetch_half, 1'b0);
        chk(fetch_req, 1'b1);
        do_wr(4'h3, 32'hFFFF_0003);
        do_fetch(32'hE1A0_1234);
        chk(instr_word, 32'hE1A0_1234);
        chk(instr_compact, 1'b0);
        chk(fetch_addr, iss_pkg::RESET_PC + iss_pkg::WIDE_STEP);
        do_rd(4'hF);
        chk(rd_data, 32'h0000_0008);
        @(posedge ref_clk);
        op_coproc <= 1'b1;
        #1;
        chk(op_undef, 1'b0);
        @(posedge ref_clk);
        op_coproc <= 1'b0;
        do_pcwr(iss_pkg::ISS_WR_LXCHG, 32'h0000_0201, 1'b0);
        chk(current_status_word[iss_pkg::STATE_BIT], 1'b0);
        chk(fetch_addr, 32'h0000_0200);
    endtask

    task automatic t_compact();
        do_pcwr(iss_pkg::ISS_WR_XCHG, 32'h0000_0101, 1'b1);
        chk(current_status_word[iss_pkg::STATE_BIT], 1'b1);
        chk(fetch_half, 1'b1);
        chk(fetch_addr, 32'h0000_0100);
        chk(flush, 1'b1);
        chk(fetch_req, 1'b0);
        chk(instr_valid, 1'b0);
        do_fetch(32'hABCD_4770);
        chk(instr_valid, 1'b1);
        chk(instr_addr, 32'h0000_0100);
        chk(instr_word, 32'h0000_4770);
        chk(instr_compact, 1'b1);
        chk(fetch_addr, 32'h0000_0102);
        do_rd(4'hF);
        chk(rd_data, 32'h0000_0100 + iss_pkg::CMP_PC_READ);
        do_rd(4'h3);
        chk(rd_data, 32'hFFFF_0003);
        chk(rd_illegal, 1'b0);
        do_rd(4'h9);
        chk(rd_illegal, 1'b1);
        @(posedge ref_clk);
        op_coproc <= 1'b1;
        #1;
        chk(op_undef, 1'b1);
        @(posedge ref_clk);
        op_coproc     <= 1'b0;
        op_status_acc <= 1'b1;
        #1;
        chk(op_undef, 1'b1);
        @(posedge ref_clk);
        op_status_acc <= 1'b0;
        do_pcwr(iss_pkg::ISS_WR_PLAIN, 32'h0000_0203, 1'b0);
        chk(fetch_addr, 32'h0000_0202);
        chk(current_status_word[iss_pkg::STATE_BIT], 1'b1);
    endtask

    // every exception kind taken in compact state, then one in 32-bit state
    task automatic t_exceptions();
        iss_pkg::iss_exc_t kinds [6];
        logic [31:0]       offs [6];
        kinds = '{iss_pkg::ISS_EXC_UNDEF, iss_pkg::ISS_EXC_SOFT, iss_pkg::ISS_EXC_PABT,
                  iss_pkg::ISS_EXC_DABT, iss_pkg::ISS_EXC_IRQ, iss_pkg::ISS_EXC_FAST};
        offs  = '{32'h2, 32'h2, 32'h4, 32'h8, 32'h4, 32'h4};
        for (int i = 0; i < 6; i++) begin
            do_pcwr(iss_pkg::ISS_WR_XCHG, 32'h0000_0401, 1'b0);
            do_exc(kinds[i], 32'h0000_0412);
            chk(link_register, 32'h0000_0412 + offs[i]);
            // handler view: secondary returns land on the next or the same halfword
            if (kinds[i] == iss_pkg::ISS_EXC_DABT) begin
                chk(link_register - 32'h0000_0006, 32'h0000_0414);
            end
            if (kinds[i] == iss_pkg::ISS_EXC_UNDEF) begin
                chk(link_register - 32'h0000_0002, 32'h0000_0412);
            end
            chk(saved_status_word[iss_pkg::STATE_BIT], 1'b1);
            chk(current_status_word[iss_pkg::STATE_BIT], 1'b0);
            chk(fetch_addr, exc_vector);
            chk(fetch_half, 1'b0);
        end
        do_exc(iss_pkg::ISS_EXC_DABT, 32'h0000_0500);
        chk(link_register, exc_wide_val);
        chk(saved_status_word[iss_pkg::STATE_BIT], 1'b0);
    endtask

    task automatic t_restore_and_late();
        do_pcwr(iss_pkg::ISS_WR_RESTORE, 32'h0000_0600, 1'b0);
        chk(current_status_word[iss_pkg::STATE_BIT], 1'b0);
        do_pcwr(iss_pkg::ISS_WR_XCHG, 32'h0000_0401, 1'b0);
        do_exc(iss_pkg::ISS_EXC_UNDEF, 32'h0000_0410);
        do_pcwr(iss_pkg::ISS_WR_RESTORE, 32'h0000_0701, 1'b0);
        chk(current_status_word[iss_pkg::STATE_BIT], 1'b1);
        chk(fetch_half, 1'b1);
        chk(fetch_addr, 32'h0000_0700);
        @(posedge ref_clk);
        late_arch <= 1'b1;
        do_pcwr(iss_pkg::ISS_WR_LOAD, 32'h0000_0800, 1'b0);
        chk(current_status_word[iss_pkg::STATE_BIT], 1'b0);
        do_pcwr(iss_pkg::ISS_WR_LXCHG, 32'h0000_0901, 1'b0);
        chk(current_status_word[iss_pkg::STATE_BIT], 1'b1);
        chk(fetch_addr, 32'h0000_0900);
        do_pcwr(iss_pkg::ISS_WR_XCHG, 32'h0000_0A00, 1'b0);
        chk(current_status_word[iss_pkg::STATE_BIT], 1'b0);
        do_rd(4'hF);
        chk(rd_illegal, 1'b0);
        // answer inside the flush cycle: dropped, pc stays on the new target
        @(posedge ref_clk);
        pc_wr_kind   <= iss_pkg::ISS_WR_PLAIN;
        pc_wr_target <= 32'h0000_0B00;
        @(posedge ref_clk);
        pc_wr_kind   <= iss_pkg::ISS_WR_NONE;
        fetch_ack    <= 1'b1;
        @(posedge ref_clk);
        fetch_ack    <= 1'b0;
        #1;
        chk(instr_valid, 1'b0);
        chk(fetch_addr, 32'h0000_0B00);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        fetch_ack = 1'b0;
        fetch_data = 32'h0;
        rd_idx = 4'h0;
        wr_en = 1'b0;
        wr_idx = 4'h0;
        wr_data = 32'h0;
        pc_wr_kind = iss_pkg::ISS_WR_NONE;
        pc_wr_target = 32'h0;
        late_arch = 1'b0;
        op_coproc = 1'b0;
        op_status_acc = 1'b0;
        exc_kind = iss_pkg::ISS_EXC_NONE;
        exc_fault_pc = 32'h0;
        exc_wide_val = 32'h0000_0C04; // distinct from any compact link value
        exc_vector = 32'h0000_0018;
        exc_mode = 5'h1B;
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1;
        // the status word only ever changes through state-selecting pc writes, restores and exceptions
        t_reset_and_wide();
        t_compact();
        t_exceptions();
        t_restore_and_late();
        finish_test();
    end
endmodule
`default_nettype wire

// ===== iss_core.sv
// instruction-state switch: fetch width, pc, register view, exception entry
`default_nettype none
// How it works
// - compact instructions are one 16-bit word
// - compact operands and addresses stay 32 bits
// - compact R0-R7 share the same storage
// - pc read in compact: bit0 zero
// - pc write in compact: bit0 discarded
// - defined compact pc read gives address plus 4
// - state flag lives at status bit 5
// - flag clear: 32-bit fetch, pc plus four
// - flag set: 16-bit fetch, pc plus two
// - branch exchange picks state from bit 0
// - link exchange and pc loads also select
// - status restore enters compact if flag set
// - exceptions switch to 32-bit before vector fetch
// - exception saves old flag in saved status
// - undefined or sw interrupt: link plus 2
// - prefetch abort: link plus 4
// - data abort: link plus 8
// - interrupts: link plus next plus 4
// - link register unknown after reset
// - compact set lacks coprocessor and status access
module iss_core (
    input  wire logic              ref_clk,       // core clock
    input  wire logic              rstn,          // async reset, active low
    // fetch side
    output logic [31:0]            fetch_addr,    // instruction fetch address
    output logic                   fetch_half,    // 1: 16-bit fetch, 0: 32-bit
    output logic                   fetch_req,     // fetch request
    input  wire logic              fetch_ack,     // fetch accepted, instruction returned
    input  wire logic [31:0]       fetch_data,    // returned instruction word
    output logic [31:0]            instr_word,    // issued instruction
    output logic [31:0]            instr_addr,    // address of issued instruction
    output logic                   instr_valid,   // issued instruction valid pulse
    output logic                   instr_compact, // issued instruction is compact
    output logic                   flush,         // discard pending fetches
    // register access from execute
    input  wire logic [3:0]        rd_idx,        // register read index
    output logic [31:0]            rd_data,       // register read data
    output logic                   rd_illegal,    // index unreachable in compact
    input  wire logic              wr_en,         // register write enable
    input  wire logic [3:0]        wr_idx,        // register write index
    input  wire logic [31:0]       wr_data,       // register write data
    // program-counter writers
    input  wire iss_pkg::iss_wr_t  pc_wr_kind,    // kind of pc write this cycle
    input  wire logic [31:0]       pc_wr_target,  // target of the pc write
    input  wire logic              late_arch,     // later architecture features present
    // operation class checks from decode
    input  wire logic              op_coproc,     // decoded coprocessor operation
    input  wire logic              op_status_acc, // decoded direct status access
    output logic                   op_undef,      // operation is undefined in this state
    // exceptions
    input  wire iss_pkg::iss_exc_t exc_kind,      // exception raised this cycle
    input  wire logic [31:0]       exc_fault_pc,  // address used for link value
    input  wire logic [31:0]       exc_wide_val,  // link value for 32-bit state
    input  wire logic [31:0]       exc_vector,    // hardware vector address
    input  wire logic [4:0]        exc_mode,      // mode bits to enter
    output logic [31:0]            link_register, // exception mode link register
    output logic [31:0]            current_status_word, // current status
    output logic [31:0]            saved_status_word    // saved status of exception mode
);
    // ---------------------------------------------------------------
    // state, pc and status
    // ---------------------------------------------------------------
    logic [31:0] pc_reg;
    logic [31:0] pc_next;
    logic [31:0] cur_reg;
    logic [31:0] cur_next;
    logic [31:0] sav_reg;
    logic [31:0] link_reg;
    logic [31:0] regs [0:iss_pkg::NUM_REGS-1];
    logic        compact;
    logic        new_state;
    logic        state_change;
    logic        exc_take;
    logic [31:0] link_val;
    logic        flush_reg;

    assign compact  = cur_reg[iss_pkg::STATE_BIT];
    assign exc_take = (exc_kind != iss_pkg::ISS_EXC_NONE);

    // target state for each pc writer
    always_comb begin
        new_state = compact;
        case (pc_wr_kind)
            iss_pkg::ISS_WR_XCHG:    new_state = pc_wr_target[0];
            iss_pkg::ISS_WR_LXCHG,
            iss_pkg::ISS_WR_LOAD:    new_state = late_arch ? pc_wr_target[0] : compact;
            iss_pkg::ISS_WR_RESTORE: new_state = sav_reg[iss_pkg::STATE_BIT];
            default:                 new_state = compact;
        endcase
        // exceptions always land in the 32-bit state
        if (exc_take) begin
            new_state = 1'b0;
        end
    end

    assign state_change = (new_state != compact);

    // next pc: exceptions win over branches, branches over sequential advance
    always_comb begin
        pc_next = pc_reg;
        if (exc_take) begin
            pc_next = exc_vector;
        end else if (pc_wr_kind != iss_pkg::ISS_WR_NONE) begin
            // bit 0 only selects the state; the pc itself is halfword aligned
            if (new_state) begin
                pc_next = {pc_wr_target[31:1], 1'b0};
            end else begin
                pc_next = {pc_wr_target[31:2], 2'b00};
            end
        end else if (fetch_ack && !flush_reg) begin
            // a refused answer must not move the pc, or the refetch skips a word
            pc_next = pc_reg + (compact ? iss_pkg::CMP_STEP
                                        : iss_pkg::WIDE_STEP);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pc_reg <= iss_pkg::RESET_PC;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // current status: new state flag and exception mode
    always_comb begin
        cur_next = cur_reg;
        if (pc_wr_kind == iss_pkg::ISS_WR_RESTORE && !exc_take) begin
            cur_next = sav_reg;
        end
        if (exc_take) begin
            cur_next[4:0] = exc_mode;
        end
        cur_next[iss_pkg::STATE_BIT] = new_state;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur_reg <= iss_pkg::RESET_STATUS;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // saved status keeps the flag in effect when the exception hit
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sav_reg <= iss_pkg::RESET_STATUS;
        end else if (exc_take) begin
            sav_reg <= cur_reg;
        end
    end

    // ---------------------------------------------------------------
    // exception link register
    // ---------------------------------------------------------------
    iss_exc_link u_link (
        .compact  (compact),
        .kind     (exc_kind),
        .fault_pc (exc_fault_pc),
        .wide_val (exc_wide_val),
        .link_val (link_val)
    );

    // no reset: its content is undefined until the first exception
    always_ff @(posedge ref_clk) begin
        if (exc_take) begin
            link_reg <= link_val;
        end
    end

    // ---------------------------------------------------------------
    // fetch control
    // ---------------------------------------------------------------
    logic [31:0] word_reg;
    logic [31:0] iaddr_reg;
    logic        ivalid_reg;
    logic        icmp_reg;

    // one-cycle drop of the stale fetch after any state change
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flush_reg <= 1'b0;
        end else begin
            flush_reg <= state_change | exc_take
                       | (pc_wr_kind != iss_pkg::ISS_WR_NONE);
        end
    end

    // issue: compact words take only the low halfword
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            word_reg   <= 32'h0000_0000;
            iaddr_reg  <= 32'h0000_0000;
            ivalid_reg <= 1'b0;
            icmp_reg   <= 1'b0;
        end else begin
            ivalid_reg <= fetch_ack & ~flush_reg & ~exc_take
                        & (pc_wr_kind == iss_pkg::ISS_WR_NONE);
            if (fetch_ack) begin
                word_reg  <= compact ? {16'h0000, fetch_data[15:0]}
                                     : fetch_data;
                iaddr_reg <= pc_reg;
                icmp_reg  <= compact;
            end
        end
    end

    assign fetch_addr    = pc_reg;
    assign fetch_half    = compact;
    assign fetch_req     = ~flush_reg;
    assign flush         = flush_reg;
    assign instr_word    = word_reg;
    assign instr_addr    = iaddr_reg;
    assign instr_valid   = ivalid_reg;
    assign instr_compact = icmp_reg;

    // ---------------------------------------------------------------
    // register file, shared by both states
    // ---------------------------------------------------------------
    // same array in both states, so the low eight need no copy
    always_ff @(posedge ref_clk) begin
        if (wr_en && wr_idx != iss_pkg::PC_INDEX) begin
            regs[wr_idx] <= wr_data;
        end
    end

    // pc reads as instruction address plus the per-state offset
    always_comb begin
        rd_data = regs[rd_idx];
        if (rd_idx == iss_pkg::PC_INDEX) begin
            if (icmp_reg) begin
                rd_data = {iaddr_reg[31:1] + iss_pkg::CMP_PC_READ[31:1], 1'b0};
            end else begin
                rd_data = iaddr_reg + (iss_pkg::WIDE_STEP << 1);
            end
        end
    end

    // high registers only through special forms, flagged to decode
    assign rd_illegal = icmp_reg & (rd_idx > iss_pkg::LOW_REG_LAST)
                      & (rd_idx != iss_pkg::PC_INDEX);

    // compact set has no coprocessor or direct status access
    assign op_undef = icmp_reg & (op_coproc | op_status_acc);

    assign link_register       = link_reg;
    assign current_status_word = cur_reg;
    assign saved_status_word   = sav_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_exc_wide;
        @(posedge ref_clk) disable iff (!rstn)
        exc_take |=> !current_status_word[iss_pkg::STATE_BIT] && fetch_addr == $past(exc_vector);
    endproperty
    a_exc_wide: assert property (p_exc_wide) else $error("exception did not enter 32-bit");

    property p_saved_flag;
        @(posedge ref_clk) disable iff (!rstn)
        exc_take |=> saved_status_word[5] == $past(compact);
    endproperty
    a_saved_flag: assert property (p_saved_flag) else $error("saved flag wrong");

    property p_link_undef;
        @(posedge ref_clk) disable iff (!rstn)
        (exc_take && compact && exc_kind == iss_pkg::ISS_EXC_UNDEF)
        |=> link_register == $past(exc_fault_pc) + 32'h0000_0002;
    endproperty
    a_link_undef: assert property (p_link_undef) else $error("undef link wrong");

    property p_link_pabt;
        @(posedge ref_clk) disable iff (!rstn)
        (exc_take && compact && exc_kind == iss_pkg::ISS_EXC_PABT)
        |=> link_register == $past(exc_fault_pc) + 32'h0000_0004;
    endproperty
    a_link_pabt: assert property (p_link_pabt) else $error("pabt link wrong");

    property p_link_dabt;
        @(posedge ref_clk) disable iff (!rstn)
        (exc_take && compact && exc_kind == iss_pkg::ISS_EXC_DABT)
        |=> link_register == $past(exc_fault_pc) + 32'h0000_0008;
    endproperty
    a_link_dabt: assert property (p_link_dabt) else $error("dabt link wrong");

    property p_link_irq;
        @(posedge ref_clk) disable iff (!rstn)
        (exc_take && compact && exc_kind inside {iss_pkg::ISS_EXC_IRQ, iss_pkg::ISS_EXC_FAST})
        |=> link_register == $past(exc_fault_pc) + 32'h0000_0004;
    endproperty
    a_link_irq: assert property (p_link_irq) else $error("irq link wrong");

    property p_xchg_state;
        @(posedge ref_clk) disable iff (!rstn)
        (!exc_take && pc_wr_kind == iss_pkg::ISS_WR_XCHG)
        |=> current_status_word[5] == $past(pc_wr_target[0]) && !fetch_addr[0];
    endproperty
    a_xchg_state: assert property (p_xchg_state) else $error("exchange state wrong");

    property p_step;
        @(posedge ref_clk) disable iff (!rstn)
        (fetch_ack && !flush && !exc_take && pc_wr_kind == iss_pkg::ISS_WR_NONE)
        |=> fetch_addr == $past(fetch_addr) + ($past(compact) ? 32'h0000_0002 : 32'h0000_0004);
    endproperty
    a_step: assert property (p_step) else $error("pc step wrong");

    property p_flush;
        @(posedge ref_clk) disable iff (!rstn)
        (state_change || exc_take) |=> flush ##1 !instr_valid;
    endproperty
    a_flush: assert property (p_flush) else $error("stale fetch issued");

    property p_pc_read;
        @(posedge ref_clk) disable iff (!rstn)
        (instr_compact && rd_idx == 4'hF) |-> rd_data == instr_addr + 32'h0000_0004 && !rd_data[0];
    endproperty
    a_pc_read: assert property (p_pc_read) else $error("compact pc read wrong");

    property p_flush_hold;
        @(posedge ref_clk) disable iff (!rstn)
        (fetch_ack && flush && !exc_take && pc_wr_kind == iss_pkg::ISS_WR_NONE)
        |=> fetch_addr == $past(fetch_addr) && !instr_valid;
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("refused fetch moved pc");

    property p_pcwr_refused;
        @(posedge ref_clk) disable iff (!rstn)
        (fetch_ack && pc_wr_kind != iss_pkg::ISS_WR_NONE)
        |=> !instr_valid;
    endproperty
    a_pcwr_refused: assert property (p_pcwr_refused) else $error("stale word issued");

    property p_undef_wide;
        @(posedge ref_clk) disable iff (!rstn)
        !instr_compact |-> !op_undef;
    endproperty
    a_undef_wide: assert property (p_undef_wide) else $error("wide op flagged undefined");
endmodule
`default_nettype wire

// ===== iss_exc_link.sv
// exception link value calculator for compact-state exceptions
`default_nettype none
module iss_exc_link (
    input  wire logic             compact,   // state flag in effect at exception
    input  wire iss_pkg::iss_exc_t kind,     // exception kind
    input  wire logic [31:0]      fault_pc,  // offending / aborted / next address
    input  wire logic [31:0]      wide_val,  // link value when in 32-bit state
    output logic [31:0]           link_val   // value loaded into link register
);
    // ---------------------------------------------------------------
    // offset selection
    // ---------------------------------------------------------------
    // only the compact state uses these offsets; the 32-bit path is passed in
    always_comb begin
        link_val = wide_val;
        if (compact) begin
            case (kind)
                iss_pkg::ISS_EXC_UNDEF,
                iss_pkg::ISS_EXC_SOFT:  link_val = fault_pc + iss_pkg::LINK_OFF_UNDEF;
                iss_pkg::ISS_EXC_PABT:  link_val = fault_pc + iss_pkg::LINK_OFF_PABT;
                iss_pkg::ISS_EXC_DABT:  link_val = fault_pc + iss_pkg::LINK_OFF_DABT;
                iss_pkg::ISS_EXC_IRQ,
                iss_pkg::ISS_EXC_FAST:  link_val = fault_pc + iss_pkg::LINK_OFF_IRQ;
                default:                link_val = wide_val;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== iss_pkg.sv
// package: constants for the instruction-state switch and exception link block
`default_nettype none
package iss_pkg;
    localparam int unsigned STATE_BIT      = 5;               // state flag position in status word
    localparam logic [31:0] WIDE_STEP      = 32'h0000_0004;   // pc advance, 32-bit state
    localparam logic [31:0] CMP_STEP       = 32'h0000_0002;   // pc advance, compact state
    localparam logic [31:0] CMP_PC_READ    = 32'h0000_0004;   // defined pc read offset, compact
    localparam logic [31:0] LINK_OFF_UNDEF = 32'h0000_0002;   // undefined / sw interrupt
    localparam logic [31:0] LINK_OFF_PABT  = 32'h0000_0004;   // prefetch abort
    localparam logic [31:0] LINK_OFF_DABT  = 32'h0000_0008;   // data abort
    localparam logic [31:0] LINK_OFF_IRQ   = 32'h0000_0004;   // normal and fast interrupt
    localparam logic [31:0] RESET_PC       = 32'h0000_0000;   // pc after reset
    localparam logic [31:0] RESET_STATUS   = 32'h0000_00D3;   // status after reset, state clear
    localparam logic [3:0]  PC_INDEX       = 4'hF;            // program_counter_reg number
    localparam logic [3:0]  LOW_REG_LAST   = 4'h7;            // last register reachable in compact
    localparam int unsigned NUM_REGS       = 16;              // general registers

    // exception kinds
    typedef enum logic [2:0] {
        ISS_EXC_NONE, ISS_EXC_UNDEF, ISS_EXC_SOFT, ISS_EXC_PABT,
        ISS_EXC_DABT, ISS_EXC_IRQ, ISS_EXC_FAST
    } iss_exc_t;

    // causes of a program-counter write
    typedef enum logic [2:0] {
        ISS_WR_NONE, ISS_WR_PLAIN, ISS_WR_XCHG, ISS_WR_LXCHG, ISS_WR_LOAD, ISS_WR_RESTORE
    } iss_wr_t;
endpackage
`default_nettype wire
